// ==== design/synth_clk_ctrl.sv ====
/*
 * Control and status for the system clock synthesizer: source select,
 * doubler, prescaler, feedback divider, frequency declaration, lock
 * detector, stability hold-off timer and calibration handshake.
 * Assumes reference and feedback edge pulses synchronous to CLK and an
 * analog calibration engine answering with a done pulse.
 */
// The plain strobed port is this design's own decision.
`default_nettype none
module synth_clk_ctrl
	import synth_clk_pkg::*;
#(
	parameter int MS_COUNT = MS_CYCLES,
	parameter int CAL_COUNT = CAL_CYCLES
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Register port
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Synthesizer loop edges
	input wire logic REF_EDGE,
	input wire logic FB_EDGE,
	// Analog configuration outputs
	output logic XTAL_AMP_EN,
	output logic DOUBLER_EN,
	output logic [1:0] PRESCALE,
	output logic [7:0] FB_DIVIDE,
	output logic [39:0] NOM_FREQ,
	// Calibration handshake
	output logic SYNTH_CAL_START,
	output logic LOOPS_CAL_START,
	input wire logic CAL_DONE,
	// Status toward timekeeping
	output logic SYNTH_LOCK,
	output logic SYNTH_STABLE,
	output logic SYNTH_CAL_BUSY
);
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_RUN = 2'b01,
		CAL_WAIT = 2'b10
	} cal_state_t;

	// Staged bytes, applied only by a transfer strobe
	logic [7:0] stage_fb;
	logic [7:0] stage_src;
	logic [7:0] stage_freq [NOM_FREQ_BYTES];
	logic [7:0] stage_hold [HOLDOFF_BYTES];
	logic [7:0] stage_op;
	logic [7:0] src_cfg;
	logic [7:0] op_ctrl;
	logic [7:0] op_prev;
	logic [19:0] holdoff;
	logic xfer;
	logic [31:0] ms_div;
	logic [19:0] ms_count;
	logic [31:0] cal_timer;
	cal_state_t cal_state;
	logic power_cal_pending;
	logic [31:0] edge_gap;
	logic gap_open;
	logic [7:0] good_edges;
	logic lock;
	logic stable;
	logic hold_clear;
	logic ms_tick;
	logic cal_go;
	logic loops_go;
	// Reset value widened to whole staging bytes; the top nibble stays zero
	localparam logic [23:0] HOLD_RESET_BYTES = 24'(HOLDOFF_RESET);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	assign xfer = WR && hit(ADDR, OFS_XFER) && WDATA[XFER_BIT];

	// Feedback ratio waits in staging until the next transfer
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			stage_fb <= FB_DIV_RESET;
		else if (WR && hit(ADDR, OFS_FB_DIV))
			stage_fb <= WDATA;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST)
			stage_src <= 8'h00;
		else if (WR && hit(ADDR, OFS_SRC_CFG))
			stage_src <= WDATA;
	end

	// Request bits stay as written; software clears them itself
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			stage_op <= 8'h00;
		else if (WR && hit(ADDR, OFS_OP_CTRL))
			stage_op <= WDATA;
	end

	// Multi-byte fields: staged per byte, loaded whole on a transfer
	genvar gi;
	generate
		for (gi = 0; gi < NOM_FREQ_BYTES; gi++) begin : g_freq
			always_ff @(posedge CLK) begin
				if (SYS_RST)
					stage_freq[gi] <= 8'h00;
				else if (WR && hit(ADDR, OFS_NOM_FREQ0 + 16'(gi)))
					stage_freq[gi] <= WDATA;
				if (SYS_RST)
					NOM_FREQ[gi*8 +: 8] <= 8'h00;
				else if (xfer)
					NOM_FREQ[gi*8 +: 8] <= stage_freq[gi];
			end
		end
		for (gi = 0; gi < HOLDOFF_BYTES; gi++) begin : g_hold
			always_ff @(posedge CLK) begin
				if (SYS_RST)
					stage_hold[gi] <= HOLD_RESET_BYTES[gi*8 +: 8];
				else if (WR && hit(ADDR, OFS_HOLDOFF0 + 16'(gi)))
					stage_hold[gi] <= WDATA;
			end
		end
	endgenerate

	// Active registers load together, so a half-written setup never reaches the loop
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			FB_DIVIDE <= FB_DIV_RESET;
		else if (xfer)
			FB_DIVIDE <= stage_fb;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST)
			src_cfg <= 8'h00;
		else if (xfer)
			src_cfg <= stage_src;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST)
			op_ctrl <= 8'h00;
		else if (xfer)
			op_ctrl <= stage_op;
	end

	// Upper nibble of the top hold-off byte is ignored
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			holdoff <= HOLDOFF_RESET;
		else if (xfer)
			holdoff <= {stage_hold[2][3:0], stage_hold[1], stage_hold[0]};
	end

	assign XTAL_AMP_EN = src_cfg[SRC_XTAL_BIT];
	// Doubler gated by crystal path; guards against a forbidden setting
	assign DOUBLER_EN = src_cfg[SRC_DOUBLER_BIT] & src_cfg[SRC_XTAL_BIT];
	assign PRESCALE = src_cfg[SRC_PRESCALE_LSB +: 2];

	// Previous request bits, for edge detection
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			op_prev <= 8'h00;
		else
			op_prev <= op_ctrl;
	end

	// A request counts on its rising edge only, so a bit left at one fires once
	assign loops_go = op_ctrl[OP_CAL_ALL_BIT] && !op_prev[OP_CAL_ALL_BIT];
	assign cal_go = (cal_state == CAL_IDLE) && (power_cal_pending || loops_go ||
		(op_ctrl[OP_CAL_SYNTH_BIT] && !op_prev[OP_CAL_SYNTH_BIT]));

	// Power-up calibration needs no request from software
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			power_cal_pending <= 1'b1;
		else if (cal_go)
			power_cal_pending <= 1'b0;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			SYNTH_CAL_START <= 1'b0;
			LOOPS_CAL_START <= 1'b0;
		end else begin
			SYNTH_CAL_START <= cal_go;
			LOOPS_CAL_START <= cal_go && loops_go;
		end
	end

	// Calibration sequencer; the timeout covers an engine that never answers
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cal_state <= CAL_IDLE;
			cal_timer <= '0;
		end else begin
			case (cal_state)
				CAL_IDLE: begin
					cal_timer <= '0;
					if (cal_go)
						cal_state <= CAL_RUN;
				end
				CAL_RUN: begin
					cal_timer <= cal_timer + 32'd1;
					if (CAL_DONE || cal_timer >= 32'(CAL_COUNT - 1))
						cal_state <= CAL_WAIT;
				end
				CAL_WAIT: cal_state <= CAL_IDLE;
				default: cal_state <= CAL_IDLE;
			endcase
		end
	end

	assign SYNTH_CAL_BUSY = (cal_state != CAL_IDLE) || power_cal_pending;

	// Lock detector: the next edge of either input must follow the previous edge within window
	always_ff @(posedge CLK) begin
		if (SYS_RST || SYNTH_CAL_BUSY) begin
			edge_gap <= '0;
			gap_open <= 1'b0;
			good_edges <= 8'h00;
			lock <= 1'b0;
		end else begin
			// Edges in one cycle count as a perfect pair
			if (REF_EDGE && FB_EDGE) begin
				gap_open <= 1'b0;
				if (good_edges < 8'(LOCK_GOOD_EDGES))
					good_edges <= good_edges + 8'd1;
				else
					lock <= 1'b1;
			end else if (REF_EDGE || FB_EDGE) begin
				if (gap_open) begin
					gap_open <= 1'b0;
					if (edge_gap <= 32'(LOCK_WIN_CYCLES)) begin
						if (good_edges < 8'(LOCK_GOOD_EDGES))
							good_edges <= good_edges + 8'd1;
						else
							lock <= 1'b1;
					end else begin
						good_edges <= 8'h00;
						lock <= 1'b0;
					end
				end else begin
					gap_open <= 1'b1;
					edge_gap <= '0;
				end
			end else if (gap_open) begin
				edge_gap <= edge_gap + 32'd1;
				if (edge_gap > 32'(LOCK_WIN_CYCLES)) begin
					gap_open <= 1'b0;
					good_edges <= 8'h00;
					lock <= 1'b0;
				end
			end
		end
	end

	assign SYNTH_LOCK = lock;

	// Hold-off timer in milliseconds; losing lock restarts it and a zero period holds it cleared
	assign hold_clear = SYS_RST || !lock || holdoff == 20'h00000;
	assign ms_tick = ms_div >= 32'(MS_COUNT - 1);

	always_ff @(posedge CLK) begin
		if (hold_clear || stable || ms_tick)
			ms_div <= '0;
		else
			ms_div <= ms_div + 32'd1;
	end

	always_ff @(posedge CLK) begin
		if (hold_clear)
			ms_count <= 20'h00000;
		else if (!stable && ms_tick)
			ms_count <= ms_count + 20'd1;
	end

	always_ff @(posedge CLK) begin
		if (hold_clear)
			stable <= 1'b0;
		else if (!stable && ms_tick && ms_count + 20'd1 >= holdoff)
			stable <= 1'b1;
	end

	// Live lock gate: stable falls in the very cycle that lock does
	assign SYNTH_STABLE = stable && lock;

	// Reads return the staged bytes; status is live
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			RDATA <= 8'h00;
		else if (RD) begin
			RDATA <= 8'h00;
			if (hit(ADDR, OFS_FB_DIV))
				RDATA <= stage_fb;
			if (hit(ADDR, OFS_SRC_CFG))
				RDATA <= stage_src;
			if (hit(ADDR, OFS_OP_CTRL))
				RDATA <= stage_op;
			for (int i = 0; i < NOM_FREQ_BYTES; i++)
				if (hit(ADDR, OFS_NOM_FREQ0 + 16'(i)))
					RDATA <= stage_freq[i];
			for (int i = 0; i < HOLDOFF_BYTES; i++)
				if (hit(ADDR, OFS_HOLDOFF0 + 16'(i)))
					RDATA <= stage_hold[i];
			if (hit(ADDR, OFS_STATUS)) begin
				RDATA[ST_LOCK_BIT] <= lock;
				RDATA[ST_STABLE_BIT] <= SYNTH_STABLE;
				RDATA[ST_CAL_BUSY_BIT] <= SYNTH_CAL_BUSY;
			end
		end else
			RDATA <= 8'h00;
	end
endmodule : synth_clk_ctrl
`default_nettype wire

// ==== design/synth_clk_pkg.sv ====
/*
 * Constants for the system clock synthesizer control block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 16-bit byte register address and an 8-bit data path.
 */
`default_nettype none
package synth_clk_pkg;
	localparam int ADDR_W = 16;
	localparam logic [15:0] OFS_FB_DIV = 16'h0200;
	localparam logic [15:0] OFS_SRC_CFG = 16'h0201;
	localparam logic [15:0] OFS_NOM_FREQ0 = 16'h0202;
	localparam logic [15:0] OFS_HOLDOFF0 = 16'h0207;
	localparam logic [15:0] OFS_OP_CTRL = 16'h2000;
	localparam logic [15:0] OFS_STATUS = 16'h3001;
	localparam logic [15:0] OFS_XFER = 16'h000F;
	localparam int NOM_FREQ_BYTES = 5;
	localparam int HOLDOFF_BYTES = 3;
	localparam int SRC_DOUBLER_BIT = 0;
	localparam int SRC_PRESCALE_LSB = 1;
	localparam int SRC_XTAL_BIT = 3;
	localparam int OP_CAL_ALL_BIT = 1;
	localparam int OP_CAL_SYNTH_BIT = 2;
	localparam int XFER_BIT = 0;
	localparam int ST_LOCK_BIT = 0;
	localparam int ST_STABLE_BIT = 1;
	localparam int ST_CAL_BUSY_BIT = 2;
	localparam logic [7:0] FB_DIV_RESET = 8'h04;
	localparam logic [7:0] FB_DIV_MIN = 8'h04;
	localparam logic [19:0] HOLDOFF_RESET = 20'h0000A;
	localparam logic [19:0] HOLDOFF_ALL_ONES = 20'hFFFFF;
	localparam int CLK_MHZ = 100;
	localparam int MS_US = 1000;
	localparam int MS_CYCLES = CLK_MHZ * MS_US;
	localparam int CAL_TIME_US = 100;
	localparam int CAL_CYCLES = CLK_MHZ * CAL_TIME_US;
	localparam int LOCK_WIN_NS = 20;
	localparam int LOCK_WIN_CYCLES = (LOCK_WIN_NS * CLK_MHZ + 999) / 1000;
	localparam int LOCK_GOOD_EDGES = 16;
endpackage : synth_clk_pkg
`default_nettype wire

// ==== verification/synth_clk_asserts.sv ====
/*
 * Port checker for the synthesizer control block.
 * Assumes a bind onto synth_clk_ctrl with its own count parameters.
 */
`default_nettype none
module synth_clk_asserts
	import synth_clk_pkg::*;
#(
	parameter int MS_COUNT = 10,
	parameter int CAL_COUNT = 20
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Register port
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	// Analog settings
	input wire logic XTAL_AMP_EN,
	input wire logic DOUBLER_EN,
	input wire logic [7:0] FB_DIVIDE,
	// Calibration and status
	input wire logic SYNTH_CAL_START,
	input wire logic LOOPS_CAL_START,
	input wire logic SYNTH_LOCK,
	input wire logic SYNTH_STABLE,
	input wire logic SYNTH_CAL_BUSY
);
	timeunit 1ns;
	timeprecision 1ps;
	// Busy may end on its own timeout, plus a little slack
	localparam int CAL_LIM = CAL_COUNT + 4;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	chk_doubler_path: assert property (DOUBLER_EN |-> XTAL_AMP_EN)
		else $error("doubler on direct path");
	chk_stable_lock: assert property (SYNTH_STABLE |-> SYNTH_LOCK && $past(SYNTH_LOCK, 8))
		else $error("stable without lock");
	chk_hold_wait: assert property ($rose(SYNTH_LOCK) |-> !SYNTH_STABLE [*8])
		else $error("stable too soon after lock");
	chk_status_read: assert property (RD && ADDR == OFS_STATUS |=> RDATA ==
		{5'h00, $past(SYNTH_CAL_BUSY), $past(SYNTH_STABLE), $past(SYNTH_LOCK)})
		else $error("status read mismatch");
	chk_loops_pair: assert property (LOOPS_CAL_START |-> SYNTH_CAL_START)
		else $error("loops start alone");
	chk_start_busy: assert property (SYNTH_CAL_START |-> SYNTH_CAL_BUSY)
		else $error("start without busy");
	chk_busy_end: assert property (SYNTH_CAL_START |-> ##[1:CAL_LIM] !SYNTH_CAL_BUSY)
		else $error("busy never ends");
	chk_start_pulse: assert property (SYNTH_CAL_START |=> !SYNTH_CAL_START)
		else $error("start longer than a pulse");
	chk_fb_xfer: assert property ($changed(FB_DIVIDE) |->
		$past(WR && ADDR == OFS_XFER && WDATA[XFER_BIT]))
		else $error("divider moved without transfer");
endmodule : synth_clk_asserts
`default_nettype wire

// ==== verification/testbench.sv ====
/*
 * Self-checking bench for the synthesizer control block.
 * Assumes the package and checker are compiled first.
 */
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR %s exp %0h got %0h", nm, e, a); end end
`define WAIT(c) begin for (n = 0; n < 400 && !(c); n++) @(negedge CLK); \
	if (!(c)) begin err_total++; final_report; end end
module testbench
	import synth_clk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 0, SYS_RST = 1, WR = 0, RD = 0, CAL_DONE = 0;
	logic REF_EDGE = 0, FB_EDGE = 0, pairs_on = 0;
	logic [15:0] ADDR = 0;
	logic [7:0] WDATA = 0, RDATA, FB_DIVIDE;
	logic [1:0] PRESCALE;
	logic [39:0] NOM_FREQ;
	logic XTAL_AMP_EN, DOUBLER_EN, SYNTH_CAL_START, LOOPS_CAL_START;
	logic SYNTH_LOCK, SYNTH_STABLE, SYNTH_CAL_BUSY;
	logic [2:0] ph = 0;
	int err_total = 0, samples_checked = 0, n, skew = 0;
	synth_clk_ctrl #(.MS_COUNT(10), .CAL_COUNT(20)) synth_clk_ctrl_inst (.CLK(CLK),
		.SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.REF_EDGE(REF_EDGE), .FB_EDGE(FB_EDGE), .XTAL_AMP_EN(XTAL_AMP_EN),
		.DOUBLER_EN(DOUBLER_EN), .PRESCALE(PRESCALE), .FB_DIVIDE(FB_DIVIDE),
		.NOM_FREQ(NOM_FREQ), .SYNTH_CAL_START(SYNTH_CAL_START),
		.LOOPS_CAL_START(LOOPS_CAL_START), .CAL_DONE(CAL_DONE), .SYNTH_LOCK(SYNTH_LOCK),
		.SYNTH_STABLE(SYNTH_STABLE), .SYNTH_CAL_BUSY(SYNTH_CAL_BUSY));
	always #5 CLK = ~CLK;
	// Skew above three cycles makes every reference-to-feedback pair a bad one
	always @(posedge CLK) begin
		ph <= ph + 3'h1;
		REF_EDGE <= pairs_on && ph == 3'h0;
		FB_EDGE <= pairs_on && ph == 3'(skew);
	end
	task automatic final_report;
		if (err_total == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		`CHK("rdata", e, RDATA)
	endtask : rd
	task automatic xfer;
		wr(OFS_XFER, 8'h01);
		@(negedge CLK);
	endtask : xfer
	task automatic t_reset;
		`CHK("fbdiv", 8'h04, FB_DIVIDE)
		`CHK("src", 4'h0, {XTAL_AMP_EN, DOUBLER_EN, PRESCALE})
		rd(OFS_STATUS, 8'h04);
		`WAIT(!SYNTH_CAL_BUSY)
	endtask : t_reset
	task automatic t_config;
		wr(OFS_FB_DIV, 8'hFF);
		wr(OFS_SRC_CFG, 8'h0F);
		rd(OFS_FB_DIV, 8'hFF);
		`CHK("staged", 8'h04, FB_DIVIDE)
		xfer;
		`CHK("fbdiv", 8'hFF, FB_DIVIDE)
		`CHK("src", 4'hF, {XTAL_AMP_EN, DOUBLER_EN, PRESCALE})
		for (int j = 0; j < 4; j++) begin
			wr(OFS_SRC_CFG, 8'(2 * j + 1));
			xfer;
			`CHK("direct", 4'(j), {XTAL_AMP_EN, DOUBLER_EN, PRESCALE})
		end
	endtask : t_config
	// 50 MHz on the direct path at ratio 46 keeps the loop at 2300 MHz
	task automatic t_freq;
		for (int i = 0; i < 5; i++)
			wr(OFS_NOM_FREQ0 + 16'(i), 8'(40'h0002FAF080 >> 8 * i));
		wr(OFS_FB_DIV, 8'h2E);
		wr(OFS_SRC_CFG, 8'h00);
		wr(OFS_HOLDOFF0, 8'h01);
		wr(OFS_HOLDOFF0 + 16'h0001, 8'h00);
		wr(OFS_HOLDOFF0 + 16'h0002, 8'hF0);
		xfer;
		`CHK("freq", 40'h0002FAF080, NOM_FREQ)
		`CHK("ratio", 8'h2E, FB_DIVIDE)
	endtask : t_freq
	task automatic t_cal;
		for (int b = 1; b <= 2; b++) begin
			wr(OFS_OP_CTRL, 8'(1 << b));
			xfer;
			`WAIT(SYNTH_CAL_START)
			`CHK("loops", b == 1, LOOPS_CAL_START)
			rd(OFS_OP_CTRL, 8'(1 << b));
			`CHK("busy", 1'b1, SYNTH_CAL_BUSY)
			@(posedge CLK);
			CAL_DONE <= 1'b1;
			@(posedge CLK);
			CAL_DONE <= 1'b0;
			`WAIT(!SYNTH_CAL_BUSY)
			wr(OFS_OP_CTRL, 8'h00);
			xfer;
		end
	endtask : t_cal
	// One millisecond is ten cycles here
	task automatic lock_hold;
		int k;
		`WAIT(SYNTH_LOCK)
		for (k = 0; k < 30 && !SYNTH_STABLE; k++) @(negedge CLK);
		`CHK("holdoff", 1'b1, k >= 9 && k <= 11)
	endtask : lock_hold
	task automatic t_lock;
		pairs_on = 1'b1;
		lock_hold;
		rd(OFS_STATUS, 8'h03);
		skew = 5;
		`WAIT(!SYNTH_LOCK)
		`CHK("stable", 1'b0, SYNTH_STABLE)
		skew = 0;
		lock_hold;
		for (int i = 0; i < 3; i++) wr(OFS_HOLDOFF0 + 16'(i), 8'h00);
		xfer;
		repeat (40) @(negedge CLK);
		rd(OFS_STATUS, 8'h01);
	endtask : t_lock
	initial begin
		repeat (10) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(negedge CLK);
		t_reset;
		t_config;
		t_freq;
		t_cal;
		t_lock;
		wr(16'h1234, 8'hAA);
		rd(16'h1234, 8'h00);
		rd(OFS_FB_DIV, 8'h2E);
		final_report;
	end
endmodule : testbench
bind synth_clk_ctrl synth_clk_asserts #(.MS_COUNT(MS_COUNT), .CAL_COUNT(CAL_COUNT))
	chk_inst (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.RD(RD), .RDATA(RDATA), .XTAL_AMP_EN(XTAL_AMP_EN), .DOUBLER_EN(DOUBLER_EN),
	.FB_DIVIDE(FB_DIVIDE), .SYNTH_CAL_START(SYNTH_CAL_START),
	.LOOPS_CAL_START(LOOPS_CAL_START), .SYNTH_LOCK(SYNTH_LOCK),
	.SYNTH_STABLE(SYNTH_STABLE), .SYNTH_CAL_BUSY(SYNTH_CAL_BUSY));
`default_nettype wire
